// >>> core/rpsc_regs.svh
`ifndef RPSC_REGS_SVH
`define RPSC_REGS_SVH

// ==========================================================================
// Register byte offsets
`define RPSC_PSC_BASE      8'h64
`define RPSC_PSC_STRIDE    8'h04
`define RPSC_TUNE_OFS      8'h6c
`define RPSC_IRQ_STAT_OFS  8'h70
`define RPSC_IRQ_CLR_OFS   8'h74
`define RPSC_IRQ_EN_OFS    8'h78

// ==========================================================================
// Port status and control field positions
`define RPSC_CURCONN_BIT   0
`define RPSC_CONNCHG_BIT   1
`define RPSC_PORTEN_BIT    2
`define RPSC_ENCHG_BIT     3
`define RPSC_OCACT_BIT     4
`define RPSC_OCCHG_BIT     5

// ==========================================================================
// Event layout inside the interrupt registers, three bits per port
`define RPSC_EV_CONN       0
`define RPSC_EV_EN         1
`define RPSC_EV_OC         2
`define RPSC_EV_PER_PORT   3

// ==========================================================================
// Tuning register
`define RPSC_TUNE_OFF_BIT  0
`define RPSC_TUNE_RESET    32'h0000_0000

`endif

// >>> core/rpsc_pkg.sv
package rpsc_pkg;

  typedef logic [31:0] rpsc_word_type;

  // Data phase that follows an accepted AHB address phase.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE
  } rpsc_phase_type;

endpackage : rpsc_pkg

// >>> core/rpsc_port_status.sv
// Operation
// [R1] Any change of overcurrent active sets the overcurrent-change flag.
// [R2] Writing one clears the overcurrent-change flag; zero does nothing.
// [R3] Overcurrent active follows the condition live and drops by itself.
// [R4] Enable-change flag sets only on disable by end-of-frame errors.
// [R5] Writing one clears the enable-change flag; zero leaves it.
// [R6] Software writing one to port-enabled never enables the port.
// [R7] Port-enabled sets only when reset finds a high-speed device.
// [R8] Port disables on fault or on software writing zero to port-enabled.
// [R9] Port-enabled holds its value until the port really changed state.
// [R10] Disabled port blocks downstream traffic except reset signalling.
// [R11] Every connect state change sets connect-change, even when already set.
// [R12] Writing one clears the connect-change flag; zero leaves it.
// [R13] Current-connect shows live device presence on the port.
// [R14] Bits zero to three read zero while port power is off.
// [R15] Tuning register lets software switch off throughput enhancements.
// [R16] One status word per port at base 64h, four bytes apart.
// [R17] Overcurrent input is synchronised before driving active and change bits.
//
// Local design decisions: the address map and the AHB-Lite slave port.

`timescale 1ns/1ps
`default_nettype none
`include "rpsc_regs.svh"

module rpsc_port_status #(
  parameter int NPORTS = 2
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Port side, one bit per port
  input  wire logic [NPORTS-1:0] overcurrentIn,
  input  wire logic [NPORTS-1:0] connectIn,
  input  wire logic [NPORTS-1:0] portPower,
  input  wire logic [NPORTS-1:0] eof2Fault,
  input  wire logic [NPORTS-1:0] resetDoneHs,
  input  wire logic [NPORTS-1:0] portResetActive,
  output logic      [NPORTS-1:0] portEnabled,
  output logic      [NPORTS-1:0] downstreamOpen,
  // Tuning and interrupt
  output logic                   throughputOff,
  output logic                   irq
);

  // ========================================================================
  // Elaboration check
  // Only two status words fit below the tuning register.
  if (NPORTS < 1 || NPORTS > 2) begin : g_bad_nports
    $error("NPORTS must be 1 or 2");
  end

  localparam int NEV = NPORTS * `RPSC_EV_PER_PORT;

  // The event registers are read back as one word, so every event must fit in it.
  if (NEV > 32) begin : g_bad_nev
    $error("Event layout does not fit one word");
  end

  function automatic logic [7:0] pscOffset(input int p);
    pscOffset = 8'(`RPSC_PSC_BASE + `RPSC_PSC_STRIDE * p);
  endfunction : pscOffset

  function automatic logic hitOfs(input logic [7:0] a, input logic [7:0] ofs);
    hitOfs = (a[7:2] == ofs[7:2]);
  endfunction : hitOfs

  function automatic int evIdx(input int p, input int kind);
    evIdx = p * `RPSC_EV_PER_PORT + kind;
  endfunction : evIdx

  // Shared by every change flag: a new event beats a clear in the same cycle.
  function automatic logic stickyNext(input logic set, input logic cur, input logic clr);
    stickyNext = set | (cur & ~clr);
  endfunction : stickyNext

  // ========================================================================
  // AHB-Lite address and data phase
  rpsc_pkg::rpsc_phase_type phase_r;
  rpsc_pkg::rpsc_phase_type phase_nxt;
  logic [7:0]               addr_r;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;

  wire        addrPhase = hsel & htrans[1] & hready;
  wire        wrPhase   = (phase_r == rpsc_pkg::PH_WRITE);
  wire [7:0]  curAddr   = haddr[7:0];

  assign phase_nxt = !addrPhase ? rpsc_pkg::PH_IDLE :
                     hwrite     ? rpsc_pkg::PH_WRITE : rpsc_pkg::PH_READ;

  wire wrTune  = wrPhase & hitOfs(addr_r, `RPSC_TUNE_OFS);
  wire wrClr   = wrPhase & hitOfs(addr_r, `RPSC_IRQ_CLR_OFS);
  wire wrIrqEn = wrPhase & hitOfs(addr_r, `RPSC_IRQ_EN_OFS);

  // The address is kept for the data phase, where the write data arrives.
  // The transfer size is not checked; every register is one whole word.
  wire [7:0]  addr_nxt  = addrPhase ? curAddr : addr_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= rpsc_pkg::PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= 8'h00;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // ========================================================================
  // Tuning and interrupt registers
  logic [31:0]    tune_r;
  logic [31:0]    tune_nxt;
  logic [NEV-1:0] irqStat_r;
  logic [NEV-1:0] irqStat_nxt;
  logic [NEV-1:0] irqEn_r;
  logic [NEV-1:0] irqEn_nxt;
  logic [NEV-1:0] events;
  logic           irq_nxt;
  logic           tuneOff_nxt;

  // A clear that meets a new event in the same cycle loses to the event.
  assign irqStat_nxt = (irqStat_r & ~(wrClr ? hwdata[NEV-1:0] : '0)) | events;

  // Only the off bit is stored; the other tuning bits read zero.
  assign tune_nxt    = wrTune ? {31'h0, hwdata[`RPSC_TUNE_OFF_BIT]} : tune_r; // R15
  assign irqEn_nxt   = wrIrqEn ? hwdata[NEV-1:0] : irqEn_r;
  assign tuneOff_nxt = tune_nxt[`RPSC_TUNE_OFF_BIT]; // R15

  // The pin is built from next-state values so it rises with its status bit.
  assign irq_nxt     = |(irqStat_nxt & irqEn_nxt);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tune_r <= `RPSC_TUNE_RESET;
    end else begin
      tune_r <= tune_nxt; // R15
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= irqStat_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqEn_r <= '0;
    end else begin
      irqEn_r <= irqEn_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      throughputOff <= 1'b0;
    end else begin
      throughputOff <= tuneOff_nxt; // R15
    end
  end

  // ========================================================================
  // Per-port status and control
  rpsc_pkg::rpsc_word_type pscWord [NPORTS];
  logic [NPORTS-1:0]       pscHit;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic ocMeta_r;
    logic ocSync_r;
    logic ocAct_r;
    logic ocChg_r;
    logic conn_r;
    logic connChg_r;
    logic en_r;
    logic enChg_r;
    logic en_nxt;

    assign pscHit[p] = hitOfs(curAddr, pscOffset(p)); // R16
    wire wrPsc = wrPhase & hitOfs(addr_r, pscOffset(p)); // R16

    // The raw pin is only ever seen by the first stage.
    wire ocEdge   = ocSync_r ^ ocAct_r; // R1
    wire connEdge = connectIn[p] ^ conn_r; // R11

    wire swDisable = wrPsc & ~hwdata[`RPSC_PORTEN_BIT]; // R8
    wire faultOff  = eof2Fault[p] & en_r; // R4
    // Loss of power drops the port too, so it never reappears enabled by itself.
    wire goOff     = swDisable | eof2Fault[p] | ~portPower[p]; // R8

    // Software has no path that raises the enable; only the reset result does.
    assign en_nxt = goOff          ? 1'b0 : // R8 R6
                    resetDoneHs[p] ? 1'b1 : en_r; // R7 R9

    wire clrOc   = wrPsc & hwdata[`RPSC_OCCHG_BIT]; // R2
    wire clrEn   = wrPsc & hwdata[`RPSC_ENCHG_BIT]; // R5
    wire clrConn = wrPsc & hwdata[`RPSC_CONNCHG_BIT]; // R12

    logic ocChg_nxt;
    logic connChg_nxt;
    logic enChg_nxt;
    logic open_nxt;

    assign ocChg_nxt   = stickyNext(ocEdge, ocChg_r, clrOc); // R1 R2
    assign connChg_nxt = stickyNext(connEdge, connChg_r, clrConn); // R11 R12
    assign enChg_nxt   = stickyNext(faultOff, enChg_r, clrEn); // R4 R5
    assign open_nxt    = en_nxt | portResetActive[p]; // R10

    // Two stages against metastability; the raw pin feeds the first stage only.
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ocMeta_r <= 1'b0;
      end else begin
        ocMeta_r <= overcurrentIn[p]; // R17
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ocSync_r <= 1'b0;
      end else begin
        ocSync_r <= ocMeta_r; // R17
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ocAct_r <= 1'b0;
      end else begin
        ocAct_r <= ocSync_r; // R3
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ocChg_r <= 1'b0;
      end else begin
        ocChg_r <= ocChg_nxt; // R1 R2
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        conn_r <= 1'b0;
      end else begin
        conn_r <= connectIn[p]; // R13
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        connChg_r <= 1'b0;
      end else begin
        connChg_r <= connChg_nxt; // R11 R12
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        en_r <= 1'b0;
      end else begin
        en_r <= en_nxt; // R9
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        enChg_r <= 1'b0;
      end else begin
        enChg_r <= enChg_nxt; // R4 R5
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        portEnabled[p] <= 1'b0;
      end else begin
        portEnabled[p] <= en_nxt;
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        downstreamOpen[p] <= 1'b0;
      end else begin
        downstreamOpen[p] <= open_nxt; // R10
      end
    end

    // Power off hides the connect and enable bits, not the overcurrent pair.
    wire pw           = portPower[p];
    wire connShown    = conn_r & pw; // R13 R14
    wire connChgShown = connChg_r & pw; // R14
    wire enShown      = en_r & pw; // R14
    wire enChgShown   = enChg_r & pw; // R14
    assign pscWord[p] = {26'h0, ocChg_r, ocAct_r, // R3
                         enChgShown, enShown, connChgShown, connShown};

    // Event strobes last one cycle and feed the interrupt status.
    assign events[evIdx(p, `RPSC_EV_CONN)] = connEdge; // R11
    assign events[evIdx(p, `RPSC_EV_EN)]   = faultOff; // R4
    assign events[evIdx(p, `RPSC_EV_OC)]   = ocEdge; // R1
  end

  // ========================================================================
  // Read data, captured in the address phase
  // Unmapped offsets read zero; the bus always answers OKAY without waits.
  wire [31:0] pscRead   = pscHit[0] ? pscWord[0] :
                          (NPORTS > 1 && pscHit[NPORTS-1]) ? pscWord[NPORTS-1] : 32'h0;
  wire [31:0] statRead  = {{(32-NEV){1'b0}}, irqStat_r};
  wire [31:0] enRead    = {{(32-NEV){1'b0}}, irqEn_r};

  wire selTune  = hitOfs(curAddr, `RPSC_TUNE_OFS);
  wire selStat  = hitOfs(curAddr, `RPSC_IRQ_STAT_OFS);
  wire selIrqEn = hitOfs(curAddr, `RPSC_IRQ_EN_OFS);
  wire rdTake   = addrPhase & ~hwrite;

  assign rdata_nxt = |pscHit  ? pscRead  :
                     selTune  ? tune_r   :
                     selStat  ? statRead :
                     selIrqEn ? enRead   : 32'h0;

  // Read data is held between reads, so a late sample still sees the snapshot.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdTake ? rdata_nxt : rdata_r;
    end
  end

  // There are no wait states and no error answers, so both stay constant.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_r;

endmodule : rpsc_port_status

`default_nettype wire

// >>> tb/rpsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port status checker
module rpsc_checker #(
  parameter int NPORTS = 2
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              resetn,
  // Bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  // Port side
  input wire logic [NPORTS-1:0] portPower,
  input wire logic [NPORTS-1:0] eof2Fault,
  input wire logic [NPORTS-1:0] resetDoneHs,
  input wire logic [NPORTS-1:0] portResetActive,
  input wire logic [NPORTS-1:0] portEnabled,
  input wire logic [NPORTS-1:0] downstreamOpen,
  input wire logic              throughputOff
);
  wire take   = hsel & htrans[1] & hready;
  wire en0Wr  = take & hwrite & (haddr[7:2] == 6'h19);
  wire tuneWr = take & hwrite & (haddr[7:2] == 6'h1b);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_tune_wr;
    tuneWr ##1 1'b1;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_held: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_en_source: assert property ($rose(portEnabled[0]) |-> $past(resetDoneHs[0]))
    else $error("port enabled without high-speed reset");
  a_fault_off: assert property (portEnabled[0] && eof2Fault[0] |=> !portEnabled[0])
    else $error("fault did not disable port");
  a_power_off: assert property (!portPower[0] |=> !portEnabled[0])
    else $error("port enabled without power");
  a_en_hold: assert property (portEnabled[0] && portPower[0] && !eof2Fault[0] && !$past(en0Wr)
    |=> portEnabled[0])
    else $error("port dropped without cause");
  a_traffic_gate: assert property (downstreamOpen[0] == (portEnabled[0] || $past(portResetActive[0])))
    else $error("downstream gate wrong");
  a_tune_set: assert property (s_tune_wr |=> throughputOff == $past(hwdata[0]))
    else $error("tuning bit not written");
  a_tune_hold: assert property ($changed(throughputOff) |-> $past(tuneWr, 2))
    else $error("tuning bit moved without a write");
endmodule : rpsc_checker

bind rpsc_port_status rpsc_checker #(.NPORTS(NPORTS)) rpsc_checker_inst (.*);
`default_nettype wire

// >>> tb/rpsc_usb_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Attached device model
module rpsc_usb_dev #(
  parameter int NPORTS = 2
) (
  // Clock
  input wire logic               sys_clk,
  // Commands
  input wire logic [NPORTS-1:0]  plug,
  input wire logic [NPORTS-1:0]  fault,
  // Port pins
  output var logic [NPORTS-1:0]  connectIn = '0,
  output var logic [NPORTS-1:0]  overcurrentIn = '0
);
  // Pins move one edge after a command, never on the sampling edge itself.
  always @(posedge sys_clk) begin
    connectIn     <= plug;
    overcurrentIn <= fault;
  end
endmodule : rpsc_usb_dev
`default_nettype wire

// >>> tb/rpsc_port_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Testbench
module rpsc_port_status_tb;
  logic        sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, hreadyout, throughputOff, irq;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
  logic [1:0]  htrans = '0, portPower = '0, eof2Fault = '0, resetDoneHs = '0;
  logic [1:0]  portResetActive = '0, plug = '0, fault = '0;
  logic [1:0]  connectIn, overcurrentIn, portEnabled, downstreamOpen;
  int          miscompares = 0, num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  rpsc_port_status rpsc_port_status_inst (.*, .hsize(3'h2), .hready(hreadyout), .hresp());
  rpsc_usb_dev rpsc_usb_dev_inst (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chkb
  task clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : clk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rdv & m);
  endtask : rc
  task enable0;
    resetDoneHs <= 2'h1;
    clk(1);
    resetDoneHs <= 2'h0;
    clk(1);
  endtask : enable0
  task t_conn;
    bus(1'b1, 8'h78, 32'h1);
    rc("irqEn", 8'h78, 32'hffffffff, 32'h1);
    plug <= 2'h1;
    clk(3);
    chkb("irq", 1'b1, irq);
    rc("conn", 8'h64, 32'h3, 32'h3);
    plug <= 2'h0;
    clk(3);
    plug <= 2'h1;
    clk(3);
    rc("reconn", 8'h64, 32'h3, 32'h3);
    bus(1'b1, 8'h64, 32'h0);
    rc("chgKept", 8'h64, 32'h2, 32'h2);
    bus(1'b1, 8'h64, 32'h2);
    rc("chgClr", 8'h64, 32'h3, 32'h1);
    bus(1'b1, 8'h74, 32'h1);
    clk(1);
    chkb("irqClr", 1'b0, irq);
    bus(1'b1, 8'h78, 32'h0);
    plug <= 2'h2;
    clk(3);
    chkb("irqMask", 1'b0, irq);
    rc("evStat", 8'h70, 32'h9, 32'h9);
    rc("port1", 8'h68, 32'h1, 32'h1);
    rc("port0", 8'h64, 32'h1, 32'h0);
    plug <= 2'h1;
    clk(3);
    $display("connect test done");
  endtask : t_conn
  task t_oc;
    fault <= 2'h1;
    clk(5);
    rc("ocOn", 8'h64, 32'h30, 32'h30);
    bus(1'b1, 8'h64, 32'h0);
    rc("ocKept", 8'h64, 32'h20, 32'h20);
    bus(1'b1, 8'h64, 32'h20);
    fault <= 2'h0;
    clk(5);
    rc("ocOff", 8'h64, 32'h30, 32'h20);
    bus(1'b1, 8'h64, 32'h20);
    rc("ocClr", 8'h64, 32'h20, 32'h0);
    $display("overcurrent test done");
  endtask : t_oc
  task t_en;
    bus(1'b1, 8'h64, 32'h4);
    clk(2);
    chkb("swEn", 1'b0, portEnabled[0]);
    enable0;
    chkb("hsEn", 1'b1, portEnabled[0]);
    chkb("openEn", 1'b1, downstreamOpen[0]);
    bus(1'b1, 8'h64, 32'h0);
    clk(1);
    chkb("swOff", 1'b0, portEnabled[0]);
    chkb("closed", 1'b0, downstreamOpen[0]);
    rc("noEnChg", 8'h64, 32'hc, 32'h0);
    portResetActive <= 2'h1;
    clk(2);
    chkb("openRst", 1'b1, downstreamOpen[0]);
    portResetActive <= 2'h0;
    enable0;
    eof2Fault <= 2'h1;
    clk(1);
    eof2Fault <= 2'h0;
    clk(1);
    chkb("faultOff", 1'b0, portEnabled[0]);
    rc("enChg", 8'h64, 32'hc, 32'h8);
    rc("evEn", 8'h70, 32'h2, 32'h2);
    bus(1'b1, 8'h64, 32'h0);
    rc("enChgKept", 8'h64, 32'h8, 32'h8);
    bus(1'b1, 8'h64, 32'h8);
    rc("enChgClr", 8'h64, 32'h8, 32'h0);
    enable0;
    portPower <= 2'h2;
    clk(2);
    chkb("pwrOff", 1'b0, portEnabled[0]);
    rc("pwrMask", 8'h64, 32'hf, 32'h0);
    portPower <= 2'h3;
    $display("enable test done");
  endtask : t_en
  task t_tune;
    bus(1'b1, 8'h6c, 32'h1);
    clk(1);
    chkb("tuneOut", 1'b1, throughputOff);
    rc("tuneRd", 8'h6c, 32'hffffffff, 32'h1);
    bus(1'b1, 8'h6c, 32'h0);
    rc("tuneClr", 8'h6c, 32'hffffffff, 32'h0);
    rc("unmapped", 8'h7c, 32'hffffffff, 32'h0);
    $display("tuning test done");
  endtask : t_tune
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    clk(5);
    resetn <= 1'b1;
    portPower <= 2'h3;
    t_conn;
    t_oc;
    t_en;
    t_tune;
    end_sim;
  end
  // The tests need well under a thousand cycles; ten thousand means a hang.
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule : rpsc_port_status_tb
`default_nettype wire
